// ==== logic/ccr_top.sv ====
// Purpose: cpu control registers (pc, flag word, stack pointer) and address map decode
// Assumes: program memory answers in the same cycle as pmem_rd_o; core stalls while busy_o
// Notes: stack pointer has no reset value, software must load it first
`timescale 1ns/100ps
`default_nettype none
module ccr_top import ccr_pkg::*; #(
  parameter int unsigned FLASH_BYTES = FLASH_DEF // 1024, 2048 or 4096
) (
  input wire logic clk_i, // 125 MHz
  input wire logic rst_i, // sync, active high
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic instr_done_i, // instruction fetched, advance pc
  input wire logic [2:0] instr_len_i, // its byte length
  input wire logic branch_i, // load pc from target
  input wire logic [15:0] branch_target_i, // immediate or register value
  input wire logic table_call_instr_i, // one-byte table call
  input wire logic [4:0] table_call_idx_i, // table entry number
  input wire logic irq_block_instr_i, // clear gate
  input wire logic irq_unblock_instr_i, // set gate
  input wire logic psw_push_instr_i, // push flag word
  input wire logic psw_pop_i, // pop flags or irq return
  input wire logic [7:0] psw_pop_data_i, // popped flag byte
  input wire logic alu_we_i, // add or subtract done
  input wire logic alu_sub_i, // 1 = subtract
  input wire logic [7:0] alu_a_i, // operand a
  input wire logic [7:0] alu_b_i, // operand b
  input wire logic rot_we_i, // rotate done
  input wire logic rot_bit_i, // bit shifted out
  input wire logic bit_we_i, // bit operation result
  input wire logic bit_val_i, // bit accumulator value
  input wire logic stack_push_i, // push one byte
  input wire logic [7:0] stack_push_data_i, // byte to push
  input wire logic stack_pop_i, // pop one byte
  input wire logic [NUM_IRQ-1:0] irq_req_i, // source requests
  input wire logic [NUM_IRQ-1:0] irq_mask_i, // 1 = source masked
  input wire logic irq_window_i, // core at instruction boundary
  input wire logic [15:0] data_addr_i, // address to decode
  output logic [15:0] pc_o, // program counter
  output logic [7:0] psw_o, // flag word
  output logic [15:0] stack_addr_o, // current stack address
  output logic stack_wr_o, // stack byte write pulse
  output logic [7:0] stack_wdata_o, // stack byte
  output logic [15:0] pmem_addr_o, // program memory address
  output logic pmem_rd_o, // program memory read
  input wire logic [7:0] pmem_rdata_i, // data in the same cycle as read
  output logic busy_o, // vector load in progress
  output logic irq_take_o, // interrupt accepted pulse
  output logic [2:0] irq_id_o, // accepted source
  output ccr_region_e dec_region_o, // region of data_addr_i
  output logic [3:0] dec_area_o // vector, table, option, protect
);
  logic [15:0] pc_q;
  logic [7:0] psw_q;
  logic [SP_BITS-1:0] sp_q;
  logic [15:0] probe_q;
  ccr_vl_e vl_q;
  logic [15:0] vaddr_q;
  logic [7:0] vlo_q;
  logic stack_wr_q;
  logic [7:0] stack_wdata_q;
  logic [15:0] pmem_addr_q;
  logic pmem_rd_q;
  ccr_region_e region_q;
  logic [3:0] area_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_go;
  logic rd_go;
  logic [NUM_IRQ-1:0] irq_ok;
  logic [2:0] irq_sel;
  logic irq_any;
  logic psw_push;
  logic push_any;
  logic [SP_BITS-1:0] sp_dec;
  logic [SP_BITS-1:0] sp_inc;
  logic [8:0] alu_r;
  logic wr_pc;
  logic wr_psw;
  logic wr_sp;
  logic [15:0] sp_wr_word;

  // ---- register bus: both write channels taken together, one write in flight
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign rd_go = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = rd_go;
  assign wr_pc = wr_go && s_axi_awaddr == OFF_PC;
  assign wr_psw = wr_go && s_axi_awaddr == OFF_PSW;
  assign wr_sp = wr_go && s_axi_awaddr == OFF_SP;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] w,
                                          input logic [3:0] s);
    return {s[1] ? w[15:8] : old[15:8], s[0] ? w[7:0] : old[7:0]};
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_pc || wr_psw || wr_sp || s_axi_awaddr == OFF_PROBE) ? RESP_OKAY
                 : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      case (s_axi_araddr)
        OFF_PC: rdata_q <= {16'h0000, pc_q};
        OFF_PSW: rdata_q <= {24'h000000, psw_q};
        OFF_SP: rdata_q <= {16'h0000, SP_HIGH, sp_q};
        OFF_STAT: rdata_q <= {24'h000000, busy_o, psw_q[FLAG_GATE], 4'h0,
                              ccr_region(probe_q, FLASH_BYTES)};
        OFF_PROBE: rdata_q <= {16'h0000, probe_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      probe_q <= PROBE_RESET;
    end else if (wr_go && s_axi_awaddr == OFF_PROBE) begin
      probe_q <= merge16(probe_q, s_axi_wdata, s_axi_wstrb);
    end
  end

  // ---- interrupt gate and source selection, lowest index wins
  assign irq_ok = irq_req_i & ~irq_mask_i & {NUM_IRQ{psw_q[FLAG_GATE]}};
  always_comb begin
    irq_sel = 3'h0;
    irq_any = 1'b0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_ok[i]) begin
        irq_sel = 3'(i);
        irq_any = 1'b1;
      end
    end
  end
  assign irq_take_o = irq_any && irq_window_i && vl_q == VL_IDLE;
  assign irq_id_o = irq_sel;
  assign busy_o = vl_q != VL_IDLE;

  // ---- two-byte vector load: reset, interrupt or table call
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vl_q <= VL_LO;
      pmem_addr_q <= RESET_VEC;
      pmem_rd_q <= 1'b1;
      vlo_q <= 8'h00;
      vaddr_q <= RESET_VEC;
    end else begin
      pmem_rd_q <= 1'b0;
      case (vl_q)
        VL_IDLE: begin
          if (irq_take_o) begin
            vl_q <= VL_LO;
            pmem_addr_q <= IRQ_VEC[irq_sel];
            vaddr_q <= IRQ_VEC[irq_sel];
            pmem_rd_q <= 1'b1;
          end else if (table_call_instr_i) begin
            vl_q <= VL_LO;
            pmem_addr_q <= TBL_CALL_BASE | {10'h000, table_call_idx_i, 1'b0};
            vaddr_q <= TBL_CALL_BASE | {10'h000, table_call_idx_i, 1'b0};
            pmem_rd_q <= 1'b1;
          end else begin
            pmem_addr_q <= pc_q;
          end
        end
        VL_LO: begin
          vlo_q <= pmem_rdata_i;
          pmem_addr_q <= vaddr_q | 16'h0001;
          pmem_rd_q <= 1'b1;
          vl_q <= VL_HI;
        end
        VL_HI: vl_q <= VL_IDLE;
        default: vl_q <= VL_IDLE;
      endcase
    end
  end

  // ---- program counter; bus write first so core activity overrides it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q <= RESET_VEC;
    end else begin
      if (wr_pc) begin
        pc_q <= merge16(pc_q, s_axi_wdata, s_axi_wstrb);
      end
      if (vl_q == VL_HI) begin
        pc_q <= {pmem_rdata_i, vlo_q};
      end else if (vl_q == VL_IDLE && branch_i) begin
        pc_q <= branch_target_i;
      end else if (vl_q == VL_IDLE && instr_done_i) begin
        pc_q <= pc_q + {13'h0000, instr_len_i};
      end
    end
  end

  // ---- flag word; hardware events win over a same-cycle bus write
  assign alu_r = alu_sub_i ? {1'b0, alu_a_i} - {1'b0, alu_b_i}
                           : {1'b0, alu_a_i} + {1'b0, alu_b_i};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psw_q <= PSW_RESET;
    end else begin
      if (wr_psw && s_axi_wstrb[0]) begin
        psw_q <= s_axi_wdata[7:0] | PSW_RESET;
      end
      if (psw_pop_i) begin
        psw_q <= psw_pop_data_i | PSW_RESET;
      end
      if (alu_we_i) begin
        psw_q[PSW_Z] <= alu_r[7:0] == 8'h00;
        psw_q[FLAG_HALF] <= alu_a_i[4] ^ alu_b_i[4] ^ alu_r[4];
        psw_q[FLAG_CARRY] <= alu_r[8];
      end else if (rot_we_i) begin
        psw_q[FLAG_CARRY] <= rot_bit_i;
      end else if (bit_we_i) begin
        psw_q[FLAG_CARRY] <= bit_val_i;
      end
      if (irq_unblock_instr_i) begin
        psw_q[FLAG_GATE] <= 1'b1;
      end
      if (irq_block_instr_i || irq_take_o) begin
        psw_q[FLAG_GATE] <= 1'b0;
      end
    end
  end
  assign psw_o = psw_q;

  // ---- stack pointer: ten bits kept, a push or pop leaving the RAM folds back
  assign psw_push = irq_take_o || psw_push_instr_i;
  assign push_any = psw_push || stack_push_i;
  assign sp_wr_word = merge16({SP_HIGH, sp_q}, s_axi_wdata, s_axi_wstrb);
  assign sp_dec = (sp_q - 10'h001 < SP_RAM_LO || sp_q - 10'h001 > SP_RAM_HI) ? SP_RAM_HI
                  : sp_q - 10'h001;
  assign sp_inc = (sp_q + 10'h001 < SP_RAM_LO || sp_q + 10'h001 > SP_RAM_HI) ? SP_RAM_LO
                  : sp_q + 10'h001;
  // no reset: contents are undefined until software loads the pointer
  always_ff @(posedge clk_i) begin
    if (wr_sp) begin
      sp_q <= sp_wr_word[SP_BITS-1:0];
    end
    if (push_any) begin
      sp_q <= sp_dec;
    end else if (stack_pop_i || psw_pop_i) begin
      sp_q <= sp_inc;
    end
  end
  // readback keeps the folded upper bits; stack traffic must land on the ram page
  assign stack_addr_o = {RAM_BASE[15:10], sp_q};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stack_wr_q <= 1'b0;
      stack_wdata_q <= 8'h00;
    end else begin
      stack_wr_q <= push_any;
      if (push_any) begin
        stack_wdata_q <= psw_push ? psw_q : stack_push_data_i;
      end
    end
  end

  // ---- address map decode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      region_q <= REG_FLASH;
      area_q <= 4'h0;
    end else begin
      region_q <= ccr_region(data_addr_i, FLASH_BYTES);
      area_q <= {data_addr_i <= VEC_TOP,
                 data_addr_i >= TBL_CALL_BASE && data_addr_i <= TBL_CALL_TOP,
                 data_addr_i == OPT_ADDR, data_addr_i == PROT_ADDR};
    end
  end

  assign pc_o = pc_q;
  assign stack_wr_o = stack_wr_q;
  assign stack_wdata_o = stack_wdata_q;
  assign pmem_addr_o = pmem_addr_q;
  assign pmem_rd_o = pmem_rd_q;
  assign dec_region_o = region_q;
  assign dec_area_o = area_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_flag_reset: assert property ($past(rst_i) |-> psw_q == PSW_RESET)
    else $error("flag word not 02h after reset");
  a_flag_bit_one: assert property (psw_o[PSW_ONE])
    else $error("flag word bit 1 not one");
  a_gate_ack_clear: assert property (irq_take_o |=> !psw_q[FLAG_GATE])
    else $error("gate still open after acknowledge");
  a_gate_refuse: assert property (!psw_q[FLAG_GATE] |-> !irq_take_o)
    else $error("interrupt taken with gate closed");
  a_mask_refuse: assert property (irq_take_o |-> !irq_mask_i[irq_id_o])
    else $error("masked source taken");
  a_irq_vector: assert property (irq_take_o |=> pmem_addr_o == IRQ_VEC[$past(irq_id_o)]
                                 ##1 pmem_addr_o == ($past(pmem_addr_o) | 16'h0001))
    else $error("wrong vector slot fetched");
  a_vector_pc: assert property (vl_q == VL_HI
                                |=> pc_q == {$past(pmem_rdata_i), $past(vlo_q)})
    else $error("pc not loaded from vector pair");
  a_pc_advance: assert property (instr_done_i && !branch_i && vl_q == VL_IDLE && !wr_pc
                                 |=> pc_q == $past(pc_q) + 16'($past(instr_len_i)))
    else $error("pc did not advance by length");
  a_stack_in_ram: assert property (stack_wr_o |-> stack_addr_o >= RAM_BASE
                                   && stack_addr_o <= RAM_TOP)
    else $error("stack write outside ram");
  a_push_predec: assert property (stack_push_i && !psw_push && sp_q == SP_RAM_LO
                                  |=> stack_wr_o && stack_addr_o == RAM_TOP)
    else $error("push from ram bottom did not wrap");
  a_region_sfr: assert property (data_addr_i >= SFR_BASE |=> dec_region_o == REG_SFR)
    else $error("sfr page not decoded");
  a_null_flag: assert property (alu_we_i
                                |=> psw_q[PSW_Z] == ($past(alu_sub_i)
                                    ? $past(alu_a_i) == $past(alu_b_i)
                                    : 8'($past(alu_a_i) + $past(alu_b_i)) == 8'h00))
    else $error("null flag wrong");

  c_irq_taken: cover property (irq_take_o ##1 busy_o [*2] ##1 !busy_o);
  c_table_call: cover property (table_call_instr_i && vl_q == VL_IDLE ##3 !busy_o);
  c_stack_wrap: cover property (push_any && sp_q == SP_RAM_LO);
endmodule
`default_nettype wire

// ==== logic/ccr_pkg.sv ====
// Purpose: constants for the cpu control register and address map block
// Assumes: 16-bit flat address space, 8-bit data, 32-bit register bus
// Notes: all offsets, flag word bit positions and the pc, flag word and probe reset values live here
package ccr_pkg;
  localparam logic [15:0] SFR_BASE = 16'hff00;
  localparam logic [15:0] RAM_BASE = 16'hfe80;
  localparam logic [15:0] RAM_TOP = 16'hfeff;
  localparam logic [15:0] VEC_TOP = 16'h0013;
  localparam logic [15:0] TBL_CALL_BASE = 16'h0040;
  localparam logic [15:0] TBL_CALL_TOP = 16'h007f;
  localparam logic [15:0] OPT_ADDR = 16'h0080;
  localparam logic [15:0] PROT_ADDR = 16'h0081;
  localparam logic [15:0] RESET_VEC = 16'h0000;
  localparam int NUM_IRQ = 6;
  // low voltage, pin 0, pin 1, 8-bit timer, 16-bit match a, match b, conversion done
  localparam logic [15:0] IRQ_VEC [NUM_IRQ+1] =
    '{16'h0006, 16'h0008, 16'h000a, 16'h000c, 16'h000e, 16'h0010, 16'h0012};
  localparam int FLASH_DEF = 4096;
  localparam logic [7:0] PSW_RESET = 8'h02;
  localparam int FLAG_GATE = 7;
  localparam int PSW_Z = 6;
  localparam int FLAG_HALF = 4;
  localparam int PSW_ONE = 1;
  localparam int FLAG_CARRY = 0;
  localparam int SP_BITS = 10;
  localparam logic [5:0] SP_HIGH = 6'h3e;
  localparam logic [SP_BITS-1:0] SP_RAM_LO = 10'h280;
  localparam logic [SP_BITS-1:0] SP_RAM_HI = 10'h2ff;
  localparam logic [7:0] OFF_PC = 8'h00;
  localparam logic [7:0] OFF_PSW = 8'h04;
  localparam logic [7:0] OFF_SP = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_PROBE = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] PROBE_RESET = 16'h0000;

  typedef enum logic [1:0] {REG_FLASH, REG_RAM, REG_SFR, REG_UNUSED} ccr_region_e;
  typedef enum logic [1:0] {VL_IDLE, VL_LO, VL_HI} ccr_vl_e;

  function automatic ccr_region_e ccr_region(input logic [15:0] a, input int unsigned fb);
    if (a >= SFR_BASE) begin
      return REG_SFR;
    end else if (a >= RAM_BASE) begin
      return REG_RAM;
    end else if (32'(a) < fb) begin
      return REG_FLASH;
    end
    return REG_UNUSED;
  endfunction
endpackage

// ==== tb/ccr_pmem_model.sv ====
// Purpose: program memory stand-in for vector and table fetches
// Assumes: byte at address a is a*25h+13h over the low eight address bits
// Notes: byte valid while read is high, inverse of last byte otherwise
`timescale 1ns/100ps
`default_nettype none
module ccr_pmem_model (
  input wire logic clk_i, // core clock
  input wire logic rd_i, // read strobe
  input wire logic [15:0] addr_i, // byte address
  output logic [7:0] data_o // read byte
);
  logic [7:0] last_q;
  // no stale byte when idle, so a late capture cannot pass by luck
  assign data_o = rd_i ? 8'(addr_i[7:0] * 8'h25 + 8'h13) : ~last_q;
  always_ff @(posedge clk_i) begin
    last_q <= data_o;
  end
endmodule
`default_nettype wire

// ==== tb/cpu_control_regs_memory_map_bench.sv ====
// Purpose: self-checking bench for cpu control registers and address decode
// Assumes: 1 KB flash; program memory answers within the read cycle
// Notes: stack pointer loaded over the bus before any stack or interrupt use
`timescale 1ns/100ps
`default_nettype none
module cpu_control_regs_memory_map_bench;
  import ccr_pkg::*;
  `define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
  `define PULSE(s) \
    @(posedge clk_i) s <= 1'b1; \
    @(posedge clk_i) s <= 1'b0; \
    @(negedge clk_i);
  typedef struct packed {logic [15:0] a; ccr_region_e rg; logic [3:0] ar;} ccr_row_s;
  localparam ccr_row_s ROWS [12] = '{
    '{16'h0000, REG_FLASH, 4'h8}, '{16'h0013, REG_FLASH, 4'h8}, '{16'h0014, REG_FLASH, 4'h0},
    '{16'h0040, REG_FLASH, 4'h4}, '{16'h007f, REG_FLASH, 4'h4}, '{16'h0080, REG_FLASH, 4'h2},
    '{16'h0081, REG_FLASH, 4'h1}, '{16'h03ff, REG_FLASH, 4'h0}, '{16'h0400, REG_UNUSED, 4'h0},
    '{16'hfe7f, REG_UNUSED, 4'h0}, '{16'hfe80, REG_RAM, 4'h0}, '{16'hff00, REG_SFR, 4'h0}};
  // operand a, operand b, subtract
  localparam logic [16:0] OPS [6] = '{{8'hff, 8'h01, 1'b0}, {8'h08, 8'h08, 1'b0},
    {8'h10, 8'h01, 1'b1}, {8'h05, 8'h05, 1'b1}, {8'h01, 8'h02, 1'b1}, {8'h12, 8'h34, 1'b0}};
  logic clk_i = 0, rst_i = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic instr_done_i = 0, branch_i = 0, table_call_instr_i = 0, irq_block_instr_i = 0;
  logic irq_unblock_instr_i = 0, psw_push_instr_i = 0, psw_pop_i = 0, alu_we_i = 0;
  logic alu_sub_i = 0, rot_we_i = 0, rot_bit_i = 0, bit_we_i = 0, bit_val_i = 0;
  logic stack_push_i = 0, stack_pop_i = 0, irq_window_i = 0;
  logic [2:0] instr_len_i = 0, irq_id_o;
  logic [15:0] branch_target_i = 0, data_addr_i = 0, pc_o, stack_addr_o, pmem_addr_o;
  logic [4:0] table_call_idx_i = 0;
  logic [7:0] psw_pop_data_i = 0, alu_a_i = 0, alu_b_i = 0, stack_push_data_i = 0;
  logic [7:0] pmem_rdata_i, psw_o, stack_wdata_o;
  logic [NUM_IRQ-1:0] irq_req_i = 0, irq_mask_i = 0;
  logic stack_wr_o, pmem_rd_o, busy_o, irq_take_o;
  ccr_region_e dec_region_o;
  logic [3:0] dec_area_o;
  int checks = 0, mismatches = 0, cycles = 0;

  ccr_top #(.FLASH_BYTES(1024)) dut_u (.clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .instr_done_i, .instr_len_i,
    .branch_i, .branch_target_i, .table_call_instr_i, .table_call_idx_i, .irq_block_instr_i,
    .irq_unblock_instr_i, .psw_push_instr_i, .psw_pop_i, .psw_pop_data_i, .alu_we_i,
    .alu_sub_i, .alu_a_i, .alu_b_i, .rot_we_i, .rot_bit_i, .bit_we_i, .bit_val_i,
    .stack_push_i, .stack_push_data_i, .stack_pop_i, .irq_req_i, .irq_mask_i, .irq_window_i,
    .data_addr_i, .pc_o, .psw_o, .stack_addr_o, .stack_wr_o, .stack_wdata_o, .pmem_addr_o,
    .pmem_rd_o, .pmem_rdata_i, .busy_o, .irq_take_o, .irq_id_o, .dec_region_o, .dec_area_o);
  ccr_pmem_model pmem_u (.clk_i, .rd_i(pmem_rd_o), .addr_i(pmem_addr_o), .data_o(pmem_rdata_i));

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 3000) begin
      mismatches++;
      test_done();
    end
  end

  function automatic logic [15:0] vec(input logic [15:0] a);
    return {8'((a[7:0] + 8'h1) * 8'h25 + 8'h13), 8'(a[7:0] * 8'h25 + 8'h13)};
  endfunction

  // the slave decides when each channel is taken; only the cycle ceiling ends a wait
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk_i);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      @(posedge clk_i);
      s_axi_awvalid <= s_axi_awvalid & ~aw;
      s_axi_wvalid <= s_axi_wvalid & ~w;
    end while (!(aw && w));
    do @(negedge clk_i); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge clk_i);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk_i); while (!s_axi_arready);
    @(posedge clk_i);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_i); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk_i);
    s_axi_rready <= 1'b0;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [8:0] s9;
    logic [4:0] h5;
    logic [7:0] a, b, pd;
    logic [2:0] fl;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK("psw", 8'h02, psw_o)
    do @(negedge clk_i); while (busy_o);
    `CHK("pc", vec(16'h0000), pc_o)
    axr(OFF_PSW, d, r);
    `CHK("psw read", 32'h02, d)
    axr(8'h14, d, r);
    `CHK("unmapped", {RESP_SLVERR, 32'h0}, {r, d})
    axw(OFF_PSW, 32'h91, r);
    `CHK("write resp", RESP_OKAY, r)
    axr(OFF_PSW, d, r);
    `CHK("psw bit1", 32'h93, d)
    axw(8'h14, 32'h0, r);
    `CHK("unmapped write", RESP_SLVERR, r)
    axw(OFF_PROBE, 32'hfe90, r);
    axr(OFF_STAT, d, r);
    `CHK("status", 32'h41, d)
    axw(OFF_SP, 32'hff00, r);
    axr(OFF_SP, d, r);
    `CHK("sp folded", 32'hfb00, d)
    $display("test bus done");
    foreach (ROWS[i]) begin
      @(posedge clk_i) data_addr_i <= ROWS[i].a;
      repeat (2) @(negedge clk_i);
      `CHK("region", ROWS[i].rg, dec_region_o)
      `CHK("area", ROWS[i].ar, dec_area_o)
    end
    $display("test decode done");
    @(posedge clk_i) stack_push_data_i <= 8'ha5;
    `PULSE(stack_push_i)
    `CHK("push", {1'b1, 16'hfeff, 8'ha5}, {stack_wr_o, stack_addr_o, stack_wdata_o})
    `PULSE(stack_pop_i)
    `CHK("pop wrap", 16'hfe80, stack_addr_o)
    `PULSE(stack_pop_i)
    `CHK("pop", 16'hfe81, stack_addr_o)
    `PULSE(psw_push_instr_i)
    `CHK("psw push", {1'b1, 16'hfe80, 8'h93}, {stack_wr_o, stack_addr_o, stack_wdata_o})
    @(posedge clk_i) psw_pop_data_i <= 8'h50;
    `PULSE(psw_pop_i)
    `CHK("psw pop", {8'h52, 16'hfe81}, {psw_o, stack_addr_o})
    `PULSE(stack_push_i)
    `PULSE(stack_push_i)
    `CHK("push wrap", {1'b1, 16'hfeff}, {stack_wr_o, stack_addr_o})
    $display("test stack done");
    @(posedge clk_i) instr_len_i <= 3'h4;
    `PULSE(instr_done_i)
    `CHK("pc step", vec(16'h0000) + 16'h4, pc_o)
    @(posedge clk_i) branch_target_i <= 16'h0321;
    @(posedge clk_i) branch_i <= 1'b1;
    @(posedge clk_i) branch_i <= 1'b0;
    @(negedge clk_i);
    `CHK("branch", 16'h0321, pc_o)
    @(posedge clk_i) table_call_idx_i <= 5'h1f;
    `PULSE(table_call_instr_i)
    do @(negedge clk_i); while (busy_o);
    `CHK("table call", vec(16'h007e), pc_o)
    $display("test pc done");
    foreach (OPS[i]) begin
      {a, b} = OPS[i][16:1];
      s9 = OPS[i][0] ? 9'(a) - 9'(b) : 9'(a) + 9'(b);
      h5 = OPS[i][0] ? 5'(a[3:0]) - 5'(b[3:0]) : 5'(a[3:0]) + 5'(b[3:0]);
      @(posedge clk_i) {alu_a_i, alu_b_i, alu_sub_i, alu_we_i} <= {OPS[i], 1'b1};
      @(posedge clk_i) alu_we_i <= 0;
      @(negedge clk_i);
      fl = {psw_o[PSW_Z], psw_o[FLAG_HALF], psw_o[FLAG_CARRY]};
      `CHK("flags", {s9[7:0] == 8'h00, h5[4], s9[8]}, fl)
    end
    @(posedge clk_i) rot_bit_i <= 1'b1;
    `PULSE(rot_we_i)
    `CHK("rot carry", 1'b1, psw_o[FLAG_CARRY])
    `PULSE(bit_we_i)
    `CHK("bit carry", 1'b0, psw_o[FLAG_CARRY])
    $display("test flags done");
    for (int k = 0; k < NUM_IRQ; k++) begin
      `PULSE(irq_unblock_instr_i)
      // lower sources masked, so source k must win
      @(posedge clk_i) irq_mask_i <= NUM_IRQ'((1 << k) - 1);
      @(posedge clk_i) {irq_req_i, irq_window_i} <= '1;
      @(negedge clk_i);
      `CHK("take", {1'b1, 3'(k)}, {irq_take_o, irq_id_o})
      pd = 8'h00;
      @(posedge clk_i) {irq_req_i, irq_window_i} <= '0;
      do begin
        @(negedge clk_i);
        if (stack_wr_o) pd = stack_wdata_o;
      end while (busy_o);
      `CHK("irq pc", vec(IRQ_VEC[k]), pc_o)
      `CHK("gate, pushed", 2'b01, {psw_o[FLAG_GATE], pd[FLAG_GATE]})
    end
    @(posedge clk_i) {irq_req_i, irq_mask_i, irq_window_i} <= {{NUM_IRQ{1'b1}}, 7'h1};
    @(negedge clk_i);
    `CHK("gate off take", 1'b0, irq_take_o)
    @(posedge clk_i) irq_mask_i <= '1;
    `PULSE(irq_unblock_instr_i)
    `CHK("masked take", 1'b0, irq_take_o)
    @(posedge clk_i) irq_req_i <= '0;
    `PULSE(irq_block_instr_i)
    `CHK("gate", 1'b0, psw_o[FLAG_GATE])
    $display("test irq done");
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK("psw again", 8'h02, psw_o)
    do @(negedge clk_i); while (busy_o);
    `CHK("pc again", vec(16'h0000), pc_o)
    $display("test reset done");
    test_done();
  end
endmodule
`default_nettype wire
